//--- rtl/pcsc_config_register.sv
// Function
// - Bits 15:13 ignore writes, read zero
// - Bit 10 puts transmitter in quiet mode
// - Bit 9 forces signal detect asserted
// - Bit 8 resets one, selects detect algorithm
// - Bit 7 selects 2ms or 722us timeout
// - Bit 5 forces good 100M link
// - Bit 2 bypasses line transition coding
module pcsc_config_register #(
    parameter int SHORT_TO_CYC = pcsc_pkg::DESC_TO_SHORT_CYC,
    parameter int LONG_TO_CYC = pcsc_pkg::DESC_TO_LONG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Management access, same clock
    input wire pcsc_pkg::pcsc_req_t req,
    output logic [15:0] rdata,
    // Control outputs to the 100M datapath
    output pcsc_pkg::pcsc_ctrl_t ctrl,
    // Selected descrambler timeout in cycles
    output logic [31:0] desc_timeout_cyc
);
    // Refuse a short timeout that is not below the long one
    initial begin
        if (SHORT_TO_CYC < 1 || LONG_TO_CYC <= SHORT_TO_CYC)
            $error("Bad descrambler timeout parameters");
    end

    // Stored register value
    logic [15:0] reg_r;
    // Address hit for the register
    logic hit;
    assign hit = req.addr == pcsc_pkg::PCS_FAST_CONFIG_STATUS_ADDR;

    // Register write; bits 15:13 are dropped, bits 12:0 are stored as written
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_r <= pcsc_pkg::RESET_VALUE;
        end else if (req.wr && hit) begin
            reg_r <= req.wdata & pcsc_pkg::WRITE_MASK;
        end
    end

    // Read data, registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (req.rd && hit) begin
            rdata <= reg_r & pcsc_pkg::WRITE_MASK;
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Control outputs, registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= '0;
            ctrl.signal_detect_algorithm_select <= 1'b1;
        end else begin
            ctrl.transmit_silence_enable <= reg_r[pcsc_pkg::TX_SILENCE_BIT];
            ctrl.force_signal_presence <= reg_r[pcsc_pkg::FORCE_SIG_BIT];
            ctrl.signal_detect_algorithm_select <= reg_r[pcsc_pkg::SD_ALG_BIT];
            ctrl.descrambler_timeout_select <= reg_r[pcsc_pkg::DESC_TO_BIT];
            ctrl.force_link_good <= reg_r[pcsc_pkg::FORCE_LINK_BIT];
            ctrl.line_code_bypass <= reg_r[pcsc_pkg::CODE_BYPASS_BIT];
        end
    end

    // Timeout length in cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            desc_timeout_cyc <= 32'(SHORT_TO_CYC);
        end else begin
            desc_timeout_cyc <= reg_r[pcsc_pkg::DESC_TO_BIT] ?
                32'(LONG_TO_CYC) : 32'(SHORT_TO_CYC);
        end
    end

    // Top bits never set
    property p_top_zero;
        @(posedge clk) disable iff (reset) rdata[15:13] == 3'h0;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("Top bits nonzero");

    // Write reaches quiet control two cycles later
    property p_quiet;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            ctrl.transmit_silence_enable == $past(req.wdata[10], 2);
    endproperty
    a_quiet: assert property (p_quiet) else $error("Quiet ctrl wrong");

    property p_force_sd;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            ctrl.force_signal_presence == $past(req.wdata[9], 2);
    endproperty
    a_force_sd: assert property (p_force_sd) else $error("Force sd wrong");

    property p_alg;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            ctrl.signal_detect_algorithm_select == $past(req.wdata[8], 2);
    endproperty
    a_alg: assert property (p_alg) else $error("Algorithm sel wrong");

    property p_timeout;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            desc_timeout_cyc == ($past(req.wdata[7], 2) ?
            32'(LONG_TO_CYC) : 32'(SHORT_TO_CYC));
    endproperty
    a_timeout: assert property (p_timeout) else $error("Timeout wrong");

    property p_link;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            ctrl.force_link_good == $past(req.wdata[5], 2);
    endproperty
    a_link: assert property (p_link) else $error("Force link wrong");

    property p_bypass;
        @(posedge clk) disable iff (reset) (req.wr && hit) |-> ##2
            ctrl.line_code_bypass == $past(req.wdata[2], 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypass wrong");

    // Readback after write returns the written low bits
    sequence s_write;
        req.wr && hit && !req.rd;
    endsequence
    sequence s_read;
        req.rd && hit && !req.wr;
    endsequence
    property p_readback;
        @(posedge clk) disable iff (reset) s_write ##1 s_read |=> 
            rdata == ($past(req.wdata, 2) & 16'h1fff);
    endproperty
    a_readback: assert property (p_readback) else $error("Readback wrong");
endmodule // pcsc_config_register

//--- rtl/pcsc_pkg.sv
package pcsc_pkg;
    // Register address on the management register space
    localparam logic [4:0] PCS_FAST_CONFIG_STATUS_ADDR = 5'h16;
    // Field positions
    localparam int TX_SILENCE_BIT = 10;
    localparam int FORCE_SIG_BIT = 9;
    localparam int SD_ALG_BIT = 8;
    localparam int DESC_TO_BIT = 7;
    localparam int FORCE_LINK_BIT = 5;
    localparam int CODE_BYPASS_BIT = 2;
    // Writable bits; bits 15:13 are never stored
    localparam logic [15:0] WRITE_MASK = 16'h1fff;
    // Reset value: only the detect algorithm select is set
    localparam logic [15:0] RESET_VALUE = 16'h0100;
    // Descrambler timeouts in microseconds and the clock rate
    localparam int DESC_TO_SHORT_US = 722;
    localparam int DESC_TO_LONG_US = 2000;
    localparam int CLK_MHZ = 200;
    localparam int DESC_TO_SHORT_CYC = DESC_TO_SHORT_US * CLK_MHZ;
    localparam int DESC_TO_LONG_CYC = DESC_TO_LONG_US * CLK_MHZ;

    // Control fields decoded from the register
    typedef struct packed {
        logic transmit_silence_enable;
        logic force_signal_presence;
        logic signal_detect_algorithm_select;
        logic descrambler_timeout_select;
        logic force_link_good;
        logic line_code_bypass;
    } pcsc_ctrl_t;

    // Management access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pcsc_req_t;
endpackage : pcsc_pkg

//--- bench/pcsc_mgmt_model.sv
// Management controller issuing single-word accesses
module pcsc_mgmt_model (
    // Clock
    input wire logic clk,
    // Register access
    output pcsc_pkg::pcsc_req_t req,
    input wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle at time zero
    initial req = '0;
    // One write pulse, then released fields inverted
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) #1;
        req = '{1'b1, 1'b0, a, d & 16'he7a4};
        @(posedge clk) #1;
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // One read pulse, data taken after the accepting edge
    task automatic read(input logic [4:0] a, output logic [15:0] q);
        @(posedge clk) #1;
        req = '{1'b0, 1'b1, a, 16'h0};
        @(posedge clk) #1;
        q = rdata;
        req = '{1'b0, 1'b0, ~a, 16'hffff};
    endtask
endmodule // pcsc_mgmt_model

//--- bench/pcsc_config_register_tb.sv
// Self-checking bench for the PCS config register
module pcsc_config_register_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    pcsc_pkg::pcsc_req_t req;
    pcsc_pkg::pcsc_ctrl_t ctrl;
    logic [15:0] rdata;
    logic [15:0] q;
    logic [31:0] tmo;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    // Rows: write data high half, expected readback low half
    logic [31:0] rows [8] = '{32'hffff07a4, 32'h04000400, 32'h02000200,
        32'h00800080, 32'h00200020, 32'h00040004, 32'h0, 32'he1000100};
    pcsc_config_register #(.SHORT_TO_CYC(10), .LONG_TO_CYC(20))
        pcsc_config_register_i (.clk(clk), .reset(reset), .req(req),
        .rdata(rdata), .ctrl(ctrl), .desc_timeout_cyc(tmo));
    pcsc_mgmt_model pcsc_mgmt_model_i (.clk(clk), .req(req), .rdata(rdata));
    // Clock, 5 ns period
    initial forever #2.5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    // Compare one value
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Outputs and readback for a stored word r
    task automatic chk_word(input logic [15:0] r);
        @(posedge clk) #1;
        chk({26'h0, ctrl}, {r[10], r[9], r[8], r[7], r[5], r[2]});
        chk(tmo, r[7] ? 32'h14 : 32'ha);
        pcsc_mgmt_model_i.read(5'h16, q);
        chk({16'h0, q}, {16'h0, r});
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk({16'h0, rdata}, 32'h0);
        chk({26'h0, ctrl}, 32'h08);
        reset = 1'b0;
        foreach (rows[i]) begin
            pcsc_mgmt_model_i.write(5'h16, rows[i][31:16]);
            chk_word(rows[i][15:0]);
        end
        // Unmapped address: write ignored, read zero
        pcsc_mgmt_model_i.write(5'h17, 16'h0404);
        chk_word(16'h0100);
        pcsc_mgmt_model_i.read(5'h17, q);
        chk({16'h0, q}, 32'h0);
        // Mid-run reset restores defaults
        pcsc_mgmt_model_i.write(5'h16, 16'h06a4);
        @(posedge clk) #1 reset = 1'b1;
        @(posedge clk) #1 reset = 1'b0;
        chk_word(16'h0100);
        stop_test();
    end
endmodule // pcsc_config_register_tb
